//--- src/fsvrb_map.svh
`ifndef FSVRB_MAP_SVH
`define FSVRB_MAP_SVH
`define FSVRB_OFS_SFC2      8'hBD
`define FSVRB_OFS_LVL       8'hBE
`define FSVRB_OFS_RAMP      8'hBF
`define FSVRB_OFS_HYST      8'hC0
`define FSVRB_RST_SFC2      2'h0
`define FSVRB_RST_LVL       8'h00
`define FSVRB_RST_RAMP      8'h00
`define FSVRB_RST_HYST      8'h44
`define FSVRB_MODE_MSB      7
`define FSVRB_MODE_LSB      6
`define FSVRB_LVL_PROC      0
`define FSVRB_LVL_GP8       2
`define FSVRB_LVL_GP9       3
`define FSVRB_LVL_GP4       4
`define FSVRB_RAMP_STEP_MS  10'h032
`define FSVRB_CLK_HZ        25000000
`define FSVRB_CYC_PER_MS    (`FSVRB_CLK_HZ / 1000)
`define FSVRB_DUTY_STEP     8'h10
`define FSVRB_DUTY_FULL     8'hFF
`define FSVRB_DUTY_ZERO     8'h00
`define FSVRB_TGT_TOP       9'h100
`define FSVRB_TGT_MIN_M0    9'h086
`define FSVRB_TGT_MIN_M7    9'h085
`define FSVRB_TGT_MIN_M3    9'h006
`endif

//--- src/fsvrb_pkg.sv
package fsvrb_pkg;
	typedef enum logic [1:0] {
		FSVRB_MODE_SIX   = 2'b00,
		FSVRB_MODE_SEVEN = 2'b01,
		FSVRB_MODE_LOW7  = 2'b10,
		FSVRB_MODE_HIGH7 = 2'b11
	} fsvrb_mode_t;
	typedef struct packed {
		fsvrb_mode_t mode;
		logic [7:0]  lvl;
		logic [7:0]  ramp;
		logic [7:0]  hyst;
	} fsvrb_regs_t;
endpackage

//--- src/fsvrb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "fsvrb_map.svh"
// How it works
// - Identification mode comes from bits 7:6 of control register two.
// - Mode 00 decodes six bits, 0.8375 V to 1.600 V, 12.5 mV steps.
// - Mode 01 decodes seven bits, 0.83125 V to 1.600 V, 6.25 mV steps.
// - Mode 10 uses bits 6:0, bit seven forced zero, 6.25 mV steps.
// - Mode 11 uses bits 7:1, bit zero forced zero, 0.0375 V up, 12.5 mV.
// - Level bit 0 selects the lower thresholds for all identification inputs.
// - Level bits 2 and 3 lower inputs 8 and 9, only in mode 00.
// - Level bits 4 to 7 lower general inputs 4 to 7 in order.
// - Ramp bits 3:0 set the step delay for the regulator-hot ramp.
// - Ramp bits 7:4 set the step delay for the processor-hot ramp.
// - Delay code n gives n times 50 ms between steps.
// - Delay code zero drives the ramp level straight to full while hot, and straight to zero when not.
// - Hysteresis bits 3:0 serve zones 1a and 1b, one degree per count.
// - Hysteresis bits 7:4 serve zones 2a and 2b, one degree per count.
// - Boost holds full duty until the zone drops more than hysteresis below.
// - Each hysteresis field is unsigned, 0 to 15 degrees.
module fsvrb_top #(
	parameter int CYC_PER_MS = `FSVRB_CYC_PER_MS
) (
	input  wire logic            clk_in,
	input  wire logic            reset_n_in,
	input  wire logic [7:0]      reg_addr_in,
	input  wire logic            reg_wr_in,
	input  wire logic [7:0]      reg_wdata_in,
	input  wire logic            reg_rd_in,
	output logic      [7:0]      reg_rdata_out,
	input  wire logic [7:0]      voltage_id_code_in,
	input  wire logic            proc_hot_input_in,
	input  wire logic            regulator_hot_input_in,
	input  wire logic [1:0][7:0] pwm_base_in,
	input  wire logic [1:0][7:0] zone_temp_in,
	input  wire logic [1:0][7:0] boost_temp_in,
	output logic      [8:0]      supply_target_out,
	output logic      [7:0]      code_used_out,
	output logic                 proc_code_low_threshold_out,
	output logic                 gp_in8_low_threshold_out,
	output logic                 gp_in9_low_threshold_out,
	output logic                 gp_in4_low_threshold_out,
	output logic                 gp_in5_low_threshold_out,
	output logic                 gp_in6_low_threshold_out,
	output logic                 gp_in7_low_threshold_out,
	output logic      [1:0][7:0] pwm_duty_out,
	output logic      [1:0]      boost_active_out
);
	////////////////////////////////////////////////////////////////////////////////
	logic rst_s1_ff;
	logic rst_n;
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rst_s1_ff <= 1'b0;
			rst_n     <= 1'b0;
		end else begin
			rst_s1_ff <= 1'b1;
			rst_n     <= rst_s1_ff;
		end
	end
	// Pins are asynchronous; only the second stage is read.
	logic [9:0] pin_s1_ff;
	logic [9:0] pin_s2_ff;
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			pin_s1_ff <= 10'h000;
			pin_s2_ff <= 10'h000;
		end else begin
			pin_s1_ff <= {proc_hot_input_in, regulator_hot_input_in, voltage_id_code_in};
			pin_s2_ff <= pin_s1_ff;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	fsvrb_pkg::fsvrb_regs_t regs_ff;
	fsvrb_pkg::fsvrb_regs_t nxt_regs;
	logic [7:0]             rdata_ff;
	logic [7:0]             nxt_rdata;
	always_comb begin
		nxt_regs  = regs_ff;
		nxt_rdata = rdata_ff;
		if (reg_wr_in) begin
			unique case (reg_addr_in)
				`FSVRB_OFS_SFC2: nxt_regs.mode = fsvrb_pkg::fsvrb_mode_t'(
					reg_wdata_in[`FSVRB_MODE_MSB:`FSVRB_MODE_LSB]);
				`FSVRB_OFS_LVL:  nxt_regs.lvl  = reg_wdata_in;
				`FSVRB_OFS_RAMP: nxt_regs.ramp = reg_wdata_in;
				`FSVRB_OFS_HYST: nxt_regs.hyst = reg_wdata_in;
				default: ;
			endcase
		end
		if (reg_rd_in) begin
			unique case (reg_addr_in)
				`FSVRB_OFS_SFC2: nxt_rdata = {regs_ff.mode, 6'h00};
				`FSVRB_OFS_LVL:  nxt_rdata = regs_ff.lvl;
				`FSVRB_OFS_RAMP: nxt_rdata = regs_ff.ramp;
				`FSVRB_OFS_HYST: nxt_rdata = regs_ff.hyst;
				default:         nxt_rdata = 8'h00;
			endcase
		end
	end
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			regs_ff  <= '{fsvrb_pkg::fsvrb_mode_t'(`FSVRB_RST_SFC2), `FSVRB_RST_LVL,
				`FSVRB_RST_RAMP, `FSVRB_RST_HYST};
			rdata_ff <= 8'h00;
		end else begin
			regs_ff  <= nxt_regs;
			rdata_ff <= nxt_rdata;
		end
	end
	assign reg_rdata_out = rdata_ff;
	////////////////////////////////////////////////////////////////////////////////
	// The decode is a linear map onto 6.25 mV units, clamped at each mode's floor.
	logic [7:0] code_ff;
	logic [7:0] nxt_code;
	logic [8:0] tgt_ff;
	logic [8:0] nxt_tgt;
	logic [8:0] tgt_min;
	logic [6:0] thr_ff;
	logic [6:0] nxt_thr;
	always_comb begin
		unique case (regs_ff.mode)
			fsvrb_pkg::FSVRB_MODE_SIX: begin
				nxt_code = {2'b00, pin_s2_ff[5:0]};
				tgt_min  = `FSVRB_TGT_MIN_M0;
			end
			fsvrb_pkg::FSVRB_MODE_SEVEN: begin
				nxt_code = {1'b0, pin_s2_ff[6:0]};
				tgt_min  = `FSVRB_TGT_MIN_M7;
			end
			fsvrb_pkg::FSVRB_MODE_LOW7: begin
				nxt_code = {1'b0, pin_s2_ff[6:0]};
				tgt_min  = `FSVRB_TGT_MIN_M7;
			end
			fsvrb_pkg::FSVRB_MODE_HIGH7: begin
				nxt_code = {pin_s2_ff[7:1], 1'b0};
				tgt_min  = `FSVRB_TGT_MIN_M3;
			end
		endcase
		// Six-bit codes count 12.5 mV, so the code weighs two units.
		if (regs_ff.mode == fsvrb_pkg::FSVRB_MODE_SIX)
			nxt_tgt = `FSVRB_TGT_TOP - {nxt_code, 1'b0};
		else
			nxt_tgt = `FSVRB_TGT_TOP - {1'b0, nxt_code};
		if (nxt_tgt < tgt_min)
			nxt_tgt = tgt_min;
		nxt_thr = {regs_ff.lvl[7:`FSVRB_LVL_GP4],
			regs_ff.lvl[`FSVRB_LVL_GP9:`FSVRB_LVL_GP8] &
			{2{regs_ff.mode == fsvrb_pkg::FSVRB_MODE_SIX}},
			regs_ff.lvl[`FSVRB_LVL_PROC]};
	end
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			code_ff <= 8'h00;
			tgt_ff  <= `FSVRB_TGT_TOP;
			thr_ff  <= 7'h00;
		end else begin
			code_ff <= nxt_code;
			tgt_ff  <= nxt_tgt;
			thr_ff  <= nxt_thr;
		end
	end
	assign code_used_out     = code_ff;
	assign supply_target_out = tgt_ff;
	assign {gp_in7_low_threshold_out, gp_in6_low_threshold_out, gp_in5_low_threshold_out,
		gp_in4_low_threshold_out, gp_in9_low_threshold_out, gp_in8_low_threshold_out,
		proc_code_low_threshold_out} = thr_ff;
	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [9:0] step_ms(input logic [3:0] code);
		step_ms = 10'(code * `FSVRB_RAMP_STEP_MS);
	endfunction
	logic [14:0] pre_ff;
	logic [14:0] nxt_pre;
	logic        tick_ff;
	logic        nxt_tick;
	always_comb begin
		nxt_tick = (pre_ff == 15'(CYC_PER_MS - 1));
		nxt_pre  = nxt_tick ? 15'h0000 : pre_ff + 15'h0001;
	end
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			pre_ff  <= 15'h0000;
			tick_ff <= 1'b0;
		end else begin
			pre_ff  <= nxt_pre;
			tick_ff <= nxt_tick;
		end
	end
	// Source 0 is the regulator-hot ramp, source 1 the processor-hot ramp.
	genvar g;
	for (g = 0; g < 2; g++) begin : g_ramp
		logic [3:0] code;
		logic       hot;
		logic [9:0] ms_ff;
		logic [9:0] nxt_ms;
		logic [7:0] lvl_ff;
		logic [7:0] nxt_lvl;
		assign code = regs_ff.ramp[4*g +: 4];
		assign hot  = pin_s2_ff[8+g];
		always_comb begin
			nxt_ms  = ms_ff;
			nxt_lvl = lvl_ff;
			if (code == 4'h0) begin
				nxt_ms  = 10'h000;
				nxt_lvl = hot ? `FSVRB_DUTY_FULL : `FSVRB_DUTY_ZERO;
			end else if (hot ? (lvl_ff == `FSVRB_DUTY_FULL) : (lvl_ff == `FSVRB_DUTY_ZERO)) begin
				nxt_ms = 10'h000;
			end else if (tick_ff) begin
				nxt_ms = ms_ff + 10'h001;
				if (nxt_ms >= step_ms(code)) begin
					nxt_ms = 10'h000;
					if (hot)
						nxt_lvl = (lvl_ff > `FSVRB_DUTY_FULL - `FSVRB_DUTY_STEP) ?
							`FSVRB_DUTY_FULL : lvl_ff + `FSVRB_DUTY_STEP;
					else
						nxt_lvl = (lvl_ff < `FSVRB_DUTY_STEP) ?
							`FSVRB_DUTY_ZERO : lvl_ff - `FSVRB_DUTY_STEP;
				end
			end
		end
		always_ff @(posedge clk_in or negedge rst_n) begin
			if (!rst_n) begin
				ms_ff  <= 10'h000;
				lvl_ff <= `FSVRB_DUTY_ZERO;
			end else begin
				ms_ff  <= nxt_ms;
				lvl_ff <= nxt_lvl;
			end
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// Widening to nine bits keeps temp plus hysteresis from wrapping.
	logic [1:0]      boost_ff;
	logic [1:0]      nxt_boost;
	logic [1:0][7:0] duty_ff;
	logic [1:0][7:0] nxt_duty;
	always_comb begin
		nxt_boost = boost_ff;
		for (int z = 0; z < 2; z++) begin
			if (zone_temp_in[z] > boost_temp_in[z])
				nxt_boost[z] = 1'b1;
			else if ({1'b0, zone_temp_in[z]} + {5'h00, regs_ff.hyst[4*z +: 4]} <
				{1'b0, boost_temp_in[z]})
				nxt_boost[z] = 1'b0;
		end
		for (int p = 0; p < 2; p++) begin
			nxt_duty[p] = pwm_base_in[p];
			if (g_ramp[0].lvl_ff > nxt_duty[p])
				nxt_duty[p] = g_ramp[0].lvl_ff;
			if (g_ramp[1].lvl_ff > nxt_duty[p])
				nxt_duty[p] = g_ramp[1].lvl_ff;
			if (|boost_ff)
				nxt_duty[p] = `FSVRB_DUTY_FULL;
		end
	end
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			boost_ff <= 2'b00;
			duty_ff  <= '0;
		end else begin
			boost_ff <= nxt_boost;
			duty_ff  <= nxt_duty;
		end
	end
	assign boost_active_out = boost_ff;
	assign pwm_duty_out     = duty_ff;
	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n);
	property p_mode_wr;
		reg_wr_in && reg_addr_in == `FSVRB_OFS_SFC2 |=> regs_ff.mode == $past(reg_wdata_in[7:6]);
	endproperty
	a_mode_wr: assert property (p_mode_wr) else $error("mode field not written");
	property p_six;
		regs_ff.mode == fsvrb_pkg::FSVRB_MODE_SIX |=>
			code_ff[7:6] == 2'b00 && tgt_ff >= `FSVRB_TGT_MIN_M0 && tgt_ff[0] == 1'b0;
	endproperty
	a_six: assert property (p_six) else $error("six-bit decode wrong");
	property p_seven;
		regs_ff.mode == fsvrb_pkg::FSVRB_MODE_SEVEN |=>
			code_ff == {1'b0, $past(pin_s2_ff[6:0])} && tgt_ff >= `FSVRB_TGT_MIN_M7;
	endproperty
	a_seven: assert property (p_seven) else $error("seven-bit decode wrong");
	property p_low7;
		regs_ff.mode == fsvrb_pkg::FSVRB_MODE_LOW7 |=> code_ff[7] == 1'b0;
	endproperty
	a_low7: assert property (p_low7) else $error("bit seven not forced zero");
	property p_high7;
		regs_ff.mode == fsvrb_pkg::FSVRB_MODE_HIGH7 |=>
			code_ff[0] == 1'b0 && tgt_ff >= `FSVRB_TGT_MIN_M3;
	endproperty
	a_high7: assert property (p_high7) else $error("bit zero not forced zero");
	property p_proc_lvl;
		regs_ff.lvl[0] |=> proc_code_low_threshold_out;
	endproperty
	a_proc_lvl: assert property (p_proc_lvl) else $error("proc threshold not lowered");
	property p_gp89;
		regs_ff.mode != fsvrb_pkg::FSVRB_MODE_SIX |=>
			!gp_in8_low_threshold_out && !gp_in9_low_threshold_out;
	endproperty
	a_gp89: assert property (p_gp89) else $error("inputs 8/9 lowered outside mode 00");
	property p_gp47;
		##1 {gp_in7_low_threshold_out, gp_in6_low_threshold_out, gp_in5_low_threshold_out,
			gp_in4_low_threshold_out} == $past(regs_ff.lvl[7:4]);
	endproperty
	a_gp47: assert property (p_gp47) else $error("inputs 4-7 thresholds wrong");
	property p_zero_full;
		g_ramp[1].hot && regs_ff.ramp[7:4] == 4'h0 |=> g_ramp[1].lvl_ff == `FSVRB_DUTY_FULL
			##1 pwm_duty_out[0] == `FSVRB_DUTY_FULL;
	endproperty
	a_zero_full: assert property (p_zero_full) else $error("code zero did not go full");
	property p_step_time;
		$past(g_ramp[0].code) != 4'h0 && $changed(g_ramp[0].lvl_ff) |->
			$past(g_ramp[0].ms_ff) + 10'h001 == step_ms($past(g_ramp[0].code));
	endproperty
	a_step_time: assert property (p_step_time) else $error("ramp step off schedule");
	property p_step_size;
		$past(g_ramp[0].code) != 4'h0 && g_ramp[0].lvl_ff > $past(g_ramp[0].lvl_ff) |->
			g_ramp[0].lvl_ff - $past(g_ramp[0].lvl_ff) <= `FSVRB_DUTY_STEP && $past(g_ramp[0].hot);
	endproperty
	a_step_size: assert property (p_step_size) else $error("ramp step too large");
	property p_boost_hold;
		boost_ff[1] && {1'b0, zone_temp_in[1]} + {5'h00, regs_ff.hyst[7:4]} >=
			{1'b0, boost_temp_in[1]} |=> boost_ff[1];
	endproperty
	a_boost_hold: assert property (p_boost_hold) else $error("boost left early");
	property p_boost_pwm;
		zone_temp_in[0] > boost_temp_in[0] |=> boost_ff[0] ##1 pwm_duty_out == {2{`FSVRB_DUTY_FULL}};
	endproperty
	a_boost_pwm: assert property (p_boost_pwm) else $error("boost did not force full");
	c_ramp_full: cover property (g_ramp[0].code != 4'h0 && g_ramp[0].lvl_ff == `FSVRB_DUTY_FULL);
	c_boost_exit: cover property (boost_ff[0] ##1 !boost_ff[0]);
	c_mode_high7: cover property (regs_ff.mode == fsvrb_pkg::FSVRB_MODE_HIGH7);
endmodule
`default_nettype wire

//--- tb/fsvrb_host.sv
`timescale 1ns/1ps
`default_nettype none
module fsvrb_host (
	input  wire logic       clk_in,
	output var  logic [7:0] addr_out,
	output var  logic       wr_out,
	output var  logic [7:0] wdata_out,
	output var  logic       rd_out,
	input  wire logic [7:0] rdata_in
);
	initial begin
		addr_out = 8'h00;
		wr_out = 1'b0;
		wdata_out = 8'h00;
		rd_out = 1'b0;
	end
	// Writes go to whatever address the caller gives; the test also writes unmapped 8'hC1, which the block ignores.
	task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_in);
		addr_out <= a;
		wdata_out <= d;
		wr_out <= 1'b1;
		@(posedge clk_in);
		wr_out <= 1'b0;
		wdata_out <= ~d;
	endtask
	task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_in);
		addr_out <= a;
		rd_out <= 1'b1;
		@(posedge clk_in);
		rd_out <= 1'b0;
		#1;
		d = rdata_in;
	endtask
endmodule
`default_nettype wire

//--- tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	localparam int CPM = 4;
	logic            clk_in, reset_n_in, wr, rd, ph, rh;
	logic [7:0]      addr, wdata, rdata, voltage_id_code, used, b, c, v;
	logic [1:0][7:0] base, temp, btemp, duty;
	logic [8:0]      target;
	logic [6:0]      thr;
	logic [1:0]      boost, m;
	logic [3:0]      h;
	logic [16:0]     e;
	int              per, mismatches, checks_done;
	fsvrb_top #(.CYC_PER_MS(CPM)) i_dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .reg_addr_in(addr),
		.reg_wr_in(wr), .reg_wdata_in(wdata), .reg_rd_in(rd), .reg_rdata_out(rdata),
		.voltage_id_code_in(voltage_id_code), .proc_hot_input_in(ph), .regulator_hot_input_in(rh),
		.pwm_base_in(base), .zone_temp_in(temp), .boost_temp_in(btemp), .supply_target_out(target),
		.code_used_out(used), .proc_code_low_threshold_out(thr[0]), .gp_in8_low_threshold_out(thr[1]),
		.gp_in9_low_threshold_out(thr[2]), .gp_in4_low_threshold_out(thr[3]),
		.gp_in5_low_threshold_out(thr[4]), .gp_in6_low_threshold_out(thr[5]),
		.gp_in7_low_threshold_out(thr[6]), .pwm_duty_out(duty), .boost_active_out(boost));
	fsvrb_host i_host (.clk_in(clk_in), .addr_out(addr), .wr_out(wr), .wdata_out(wdata), .rd_out(rd),
		.rdata_in(rdata));
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clk_in = 1'b0;
		forever #20 clk_in = ~clk_in;
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] x);
		logic [7:0] d;
		i_host.read_reg(a, d);
		chk(16'(d), 16'(x), "register read");
	endtask
	task automatic test_done();
		$display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Mode 11 doubles bits 7:1, which equals the code with bit zero cleared.
	function automatic logic [16:0] exp_dec(input logic [1:0] md, input logic [7:0] cd);
		logic [7:0] u;
		int t, lo;
		u = (md == 2'b00) ? (cd & 8'h3F) : (md == 2'b11) ? (cd & 8'hFE) : (cd & 8'h7F);
		t = (md == 2'b00) ? 256 - 2 * int'(u) : 256 - int'(u);
		lo = (md == 2'b00) ? 134 : (md == 2'b11) ? 6 : 133;
		if (t < lo)
			t = lo;
		return {u, 9'(t)};
	endfunction
	function automatic logic [6:0] exp_thr(input logic [1:0] md, input logic [7:0] x);
		return {x[7:4], x[3] & (md == 2'b00), x[2] & (md == 2'b00), x[0]};
	endfunction
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20000) @(posedge clk_in);
		mismatches++;
		$display("CHECK FAILED t=%0t watchdog expired", $time);
		test_done();
	end
	initial begin
		{reset_n_in, ph, rh} = 3'b000;
		{voltage_id_code, base, temp, btemp} = '0;
		void'($urandom(54));
		repeat (12) @(posedge clk_in);
		reset_n_in <= 1'b1;
		repeat (3) @(posedge clk_in);
		rdc(8'hBD, 8'h00);
		rdc(8'hBE, 8'h00);
		rdc(8'hBF, 8'h00);
		rdc(8'hC0, 8'h44);
		rdc(8'h55, 8'h00);
		i_host.write_reg(8'hC1, 8'h55);
		rdc(8'hC0, 8'h44);
		$display("test reset_and_map done");
		for (int i = 0; i < 16; i++) begin
			m = 2'(i);
			v = 8'($urandom);
			c = (i inside {[4:7]}) ? {8{i[0]}} : 8'($urandom);
			i_host.write_reg(8'hBD, {m, v[5:4], 4'h0});
			rdc(8'hBD, {m, 6'h00});
			i_host.write_reg(8'hBE, v);
			rdc(8'hBE, v);
			@(posedge clk_in) voltage_id_code <= c;
			repeat (5) @(posedge clk_in);
			#1 e = exp_dec(m, c);
			chk(16'(used), 16'(e[16:9]), "code used");
			chk(16'(target), 16'(e[8:0]), "target");
			chk(16'(thr), 16'(exp_thr(m, v)), "thresholds");
		end
		$display("test decode_levels done");
		for (int s = 0; s < 2; s++) begin
			per = (s + 1) * 50 * CPM;
			b = 8'($urandom_range(0, 15));
			@(posedge clk_in) base <= {b, b};
			i_host.write_reg(8'hBF, s ? 8'h20 : 8'h01);
			for (int k = 0; k < 2; k++) begin
				@(posedge clk_in);
				ph <= (s == 1) && (k == 0);
				rh <= (s == 0) && (k == 0);
				// The interval count runs on across release, so the step down lands one interval after the step up.
				repeat (k ? per - 120 : per - 50) @(posedge clk_in);
				#1 chk(duty, k ? 16'h1010 : {b, b}, "ramp early");
				repeat (120) @(posedge clk_in);
				#1 chk(duty, k ? {b, b} : 16'h1010, "ramp step");
			end
		end
		i_host.write_reg(8'hBF, 8'h00);
		for (int k = 0; k < 4; k++) begin
			@(posedge clk_in);
			ph <= (k == 0);
			rh <= (k == 2);
			repeat (6) @(posedge clk_in);
			#1 chk(duty, k[0] ? {b, b} : 16'hFFFF, "zero delay");
		end
		$display("test ramp done");
		for (int z = 0; z < 2; z++) begin
			h = z ? 4'hF : 4'($urandom);
			i_host.write_reg(8'hC0, z ? {h, 4'h3} : {4'h9, h});
			rdc(8'hC0, z ? {h, 4'h3} : {4'h9, h});
			@(posedge clk_in);
			btemp <= {8'h64, 8'h64};
			temp <= '0;
			for (int p = 0; p < 4; p++) begin
				@(posedge clk_in) temp[z] <= (p < 2) ? 8'(100 + p) : 8'(102 - p - int'(h));
				repeat (4) @(posedge clk_in);
				#1 chk(16'(boost), (p == 1 || p == 2) ? 16'(1 << z) : 16'h0000, "boost");
				chk(duty, (p == 1 || p == 2) ? 16'hFFFF : {b, b}, "boost duty");
			end
		end
		$display("test boost done");
		test_done();
	end
endmodule
`default_nettype wire
